// >>> verilog/cfs_regs.vh
// Register indices, field positions, reset values and operation codes
// of the core sequencing block. Byte address on the bus is four times
// the register index; definitions only.
`ifndef CFS_REGS_VH
`define CFS_REGS_VH

// Register indices
`define CFS_IDX_LOOKUP    8'h82
`define CFS_IDX_FLAGS     8'h86
`define CFS_IDX_PCL       8'hCE
`define CFS_IDX_PCH       8'hCF
`define CFS_IDX_STACK_POINTER_CTL      8'hDF
`define CFS_IDX_STK_HI    4'hF

// Field positions
`define CFS_FLAG_C        2
`define CFS_FLAG_DC       1
`define CFS_FLAG_Z        0
`define CFS_STACK_POINTER_CTL_GIE      7

// Reset values and interrupt entry vector
`define CFS_FLAGS_RST     3'h0
`define CFS_SP_RST        4'hF
`define CFS_GIE_RST       1'b0
`define CFS_PC_RST        12'h000
`define CFS_ACC_RST       8'h00
`define CFS_LOOKUP_RST    8'h00
`define CFS_IRQ_VEC       12'h008

// Operation codes from the instruction decoder
`define CFS_OP_NEXT       5'h00
`define CFS_OP_ADD        5'h01
`define CFS_OP_SUB        5'h02
`define CFS_OP_RRC        5'h03
`define CFS_OP_RLC        5'h04
`define CFS_OP_LDA        5'h05
`define CFS_OP_XCH        5'h06
`define CFS_OP_JMP        5'h07
`define CFS_OP_CALL       5'h08
`define CFS_OP_RET        5'h09
`define CFS_OP_RETURN_FROM_INTERRUPT       5'h0A
`define CFS_OP_IENT       5'h0B
`define CFS_OP_COMPARE_SKIP      5'h0C
`define CFS_OP_INCSK      5'h0D
`define CFS_OP_DECSK      5'h0E
`define CFS_OP_BIT_CLEAR_SKIP       5'h0F
`define CFS_OP_BIT_SET_SKIP       5'h10
`define CFS_OP_ADDPC      5'h11

`endif

// >>> verilog/cfs_core.v
// Flags, accumulator, return stack and program counter of the core.
// Assumes a decoder on the same clock giving one ex_valid pulse per
// executed instruction, and an APB master for the system registers.
//
// How it works
// RQ1 - Flag register holds carry, nibble carry, zero; cleared at reset.
// RQ2 - Carry set on add carry-out, subtract without borrow, rotate-out one.
// RQ3 - Nibble carry set on low-nibble carry, or subtract without nibble borrow.
// RQ4 - Zero flag follows whether an add or subtract result is zero.
// RQ5 - Accumulator is 8 bits and has no register address.
// RQ6 - Interrupt entry and pops leave the accumulator alone; exchange is flag-neutral.
// RQ7 - Eight-level, 12-bit last-in-first-out return stack.
// RQ8 - Stack pointer register: pointer in 3:0 resets to 1111, enable in bit 7.
// RQ9 - Save decrements the pointer, restore increments it.
// RQ10 - Calls and interrupt entry push the program counter.
// RQ11 - Level n uses pointer 15 minus n and entry n.
// RQ12 - Both returns pop the top entry into the program counter.
// RQ13 - Each entry visible as high and low byte registers, read-write.
// RQ14 - 12-bit program counter resets to zero, steps by one.
// RQ15 - Jump and call load the full 12-bit destination.
// RQ16 - Counter high nibble and low byte readable and writable.
// RQ17 - Conditional skip instructions advance the counter by two.
// RQ18 - Compare skips when accumulator equals the operand.
// RQ19 - Increment and decrement skip when the result is zero.
// RQ20 - Writing or adding into the low byte keeps the high nibble.
// RQ21 - No stack overflow indication; pointer wraps modulo sixteen.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns

`include "cfs_regs.vh"

module cfs_core #(
    parameter [11:0] IRQ_VECTOR = `CFS_IRQ_VEC
) (
    input  wire        clock,
    input  wire        rstn,
    input  wire [9:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        ex_valid,
    input  wire [4:0]  ex_op,
    input  wire [7:0]  ex_operand,
    input  wire [11:0] ex_target,
    input  wire [2:0]  ex_bit,
    input  wire        ex_to_mem,
    output wire [7:0]  accumulator,
    output wire [11:0] pc_out,
    output wire [7:0]  res_data,
    output wire        res_we,
    output wire        global_irq_enable
);

    reg [7:0]  acc_reg;
    reg [7:0]  acc_next;
    reg [11:0] pc_reg;
    reg [11:0] pc_next;
    reg        carry_reg;
    reg        carry_next;
    reg        nibble_carry_flag;
    reg        nibble_carry_next;
    reg        zero_reg;
    reg        zero_next;
    reg [3:0]  sp_reg;
    reg [3:0]  sp_next;
    reg        gie_reg;
    reg [7:0]  lookup_reg;
    reg [7:0]  res_data_reg;
    reg [7:0]  res_data_next;
    reg        res_we_reg;
    reg        res_we_next;
    reg [31:0] prdata_reg;
    reg        ex_prev_reg;
    reg        push_en;
    reg [11:0] push_val;
    reg [11:0] stk [0:7];
    reg [7:0]  rd_mux;
    reg        mapped;

    wire [7:0] idx = paddr[9:2];
    wire       is_stk = (idx[7:4] == `CFS_IDX_STK_HI);
    // Entry 7 sits at the lowest index pair, entry 0 at the top
    wire [2:0] stk_ent = 3'h7 - idx[3:1];
    wire       wr_fire = psel & penable & pwrite & pready & pstrb[0] & mapped;

    wire [8:0] add_full = {1'b0, acc_reg} + {1'b0, ex_operand};
    wire [4:0] add_low = {1'b0, acc_reg[3:0]} + {1'b0, ex_operand[3:0]};
    wire [7:0] sub_val = acc_reg - ex_operand;
    wire [7:0] inc_val = ex_operand + 8'h01;
    wire [7:0] dec_val = ex_operand - 8'h01;
    wire [11:0] pc_step = pc_reg + 12'h001;
    wire [11:0] pc_skip = pc_reg + 12'h002;
    wire [3:0] sp_up = sp_reg + 4'h1;

    // Entry used for a pointer value; only the low bits matter
    function [2:0] level_of;
        input [3:0] sp;
        begin
            level_of = ~sp[2:0]; // RQ11
        end
    endfunction

    // Pointer after a save; a save at pointer zero simply wraps to 15, no flag
    function [3:0] ptr_after_save;
        input [3:0] sp;
        begin
            ptr_after_save = sp - 4'h1; // RQ21
        end
    endfunction

    // Bus answer waits one cycle after an execute so that reads and
    // writes never race the core updating the same state.
    assign pready = ~ex_valid & ~ex_prev_reg;
    assign pslverr = psel & penable & pready & ~mapped;
    assign prdata = prdata_reg;
    assign accumulator = acc_reg;
    assign pc_out = pc_reg;
    assign res_data = res_data_reg;
    assign res_we = res_we_reg;
    assign global_irq_enable = gie_reg;

    // Register readback; accumulator deliberately absent
    always @* begin
        rd_mux = 8'h00;
        mapped = 1'b1;
        if (is_stk) begin
            if (idx[0]) begin
                rd_mux = {4'h0, stk[stk_ent][11:8]}; // RQ13
            end else begin
                rd_mux = stk[stk_ent][7:0]; // RQ13
            end
        end else begin
            case (idx)
                `CFS_IDX_LOOKUP: begin
                    rd_mux = lookup_reg;
                end
                `CFS_IDX_FLAGS: begin
                    rd_mux = {5'h00, carry_reg, nibble_carry_flag, zero_reg}; // RQ1
                end
                `CFS_IDX_PCL: begin
                    rd_mux = pc_reg[7:0]; // RQ16
                end
                `CFS_IDX_PCH: begin
                    rd_mux = {4'h0, pc_reg[11:8]}; // RQ16
                end
                `CFS_IDX_STACK_POINTER_CTL: begin
                    rd_mux = {gie_reg, 3'h0, sp_reg}; // RQ8
                end
                default: begin
                    mapped = 1'b0; // RQ5
                end
            endcase
        end
    end

    // Execute: next state of flags, accumulator, counter and pointer
    always @* begin
        acc_next = acc_reg;
        carry_next = carry_reg;
        nibble_carry_next = nibble_carry_flag;
        zero_next = zero_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        push_en = 1'b0;
        push_val = pc_step;
        res_data_next = res_data_reg;
        res_we_next = 1'b0;
        if (ex_valid) begin
            pc_next = pc_step; // RQ14
            case (ex_op)
                `CFS_OP_NEXT: begin
                    pc_next = pc_step;
                end
                `CFS_OP_ADD: begin
                    carry_next = add_full[8]; // RQ2
                    nibble_carry_next = add_low[4]; // RQ3
                    zero_next = (add_full[7:0] == 8'h00); // RQ4
                    if (ex_to_mem) begin
                        res_data_next = add_full[7:0];
                        res_we_next = 1'b1;
                    end else begin
                        acc_next = add_full[7:0];
                    end
                end
                `CFS_OP_SUB: begin
                    carry_next = (acc_reg >= ex_operand); // RQ2
                    nibble_carry_next = (acc_reg[3:0] >= ex_operand[3:0]); // RQ3
                    zero_next = (sub_val == 8'h00); // RQ4
                    if (ex_to_mem) begin
                        res_data_next = sub_val;
                        res_we_next = 1'b1;
                    end else begin
                        acc_next = sub_val;
                    end
                end
                `CFS_OP_RRC: begin
                    carry_next = ex_operand[0]; // RQ2
                    if (ex_to_mem) begin
                        res_data_next = {carry_reg, ex_operand[7:1]};
                        res_we_next = 1'b1;
                    end else begin
                        acc_next = {carry_reg, ex_operand[7:1]};
                    end
                end
                `CFS_OP_RLC: begin
                    carry_next = ex_operand[7]; // RQ2
                    if (ex_to_mem) begin
                        res_data_next = {ex_operand[6:0], carry_reg};
                        res_we_next = 1'b1;
                    end else begin
                        acc_next = {ex_operand[6:0], carry_reg};
                    end
                end
                `CFS_OP_LDA: begin
                    acc_next = ex_operand;
                end
                `CFS_OP_XCH: begin
                    // Only way to park the accumulator without touching flags
                    acc_next = ex_operand; // RQ6
                    res_data_next = acc_reg;
                    res_we_next = 1'b1;
                end
                `CFS_OP_JMP: begin
                    pc_next = ex_target; // RQ15
                end
                `CFS_OP_CALL: begin
                    push_en = 1'b1; // RQ10
                    push_val = pc_step;
                    sp_next = ptr_after_save(sp_reg); // RQ9
                    pc_next = ex_target; // RQ15
                end
                `CFS_OP_RET, `CFS_OP_RETURN_FROM_INTERRUPT: begin
                    // Leaving a handler does not set the enable bit again
                    pc_next = stk[level_of(sp_up)]; // RQ12
                    sp_next = sp_up; // RQ9
                end
                `CFS_OP_IENT: begin
                    // Interrupted instruction resumes; accumulator untouched
                    push_en = 1'b1; // RQ10
                    push_val = pc_reg; // RQ6
                    // Enable bit left alone; masking belongs to the controller
                    sp_next = ptr_after_save(sp_reg); // RQ9
                    pc_next = IRQ_VECTOR;
                end
                `CFS_OP_COMPARE_SKIP: begin
                    if (acc_reg == ex_operand) begin
                        pc_next = pc_skip; // RQ18
                    end
                end
                `CFS_OP_INCSK: begin
                    if (ex_to_mem) begin
                        res_data_next = inc_val;
                        res_we_next = 1'b1;
                    end else begin
                        acc_next = inc_val;
                    end
                    if (inc_val == 8'h00) begin
                        pc_next = pc_skip; // RQ19
                    end
                end
                `CFS_OP_DECSK: begin
                    if (ex_to_mem) begin
                        res_data_next = dec_val;
                        res_we_next = 1'b1;
                    end else begin
                        acc_next = dec_val;
                    end
                    if (dec_val == 8'h00) begin
                        pc_next = pc_skip; // RQ19
                    end
                end
                `CFS_OP_BIT_CLEAR_SKIP: begin
                    if (!ex_operand[ex_bit]) begin
                        pc_next = pc_skip; // RQ17
                    end
                end
                `CFS_OP_BIT_SET_SKIP: begin
                    if (ex_operand[ex_bit]) begin
                        pc_next = pc_skip; // RQ17
                    end
                end
                `CFS_OP_ADDPC: begin
                    // Carry out of the low byte is dropped
                    pc_next = {pc_reg[11:8], pc_reg[7:0] + acc_reg}; // RQ20
                end
                default: begin
                    pc_next = pc_step;
                end
            endcase
        end
    end

    // Core state; bus writes only land when no execute is in flight
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= `CFS_ACC_RST;
            pc_reg <= `CFS_PC_RST; // RQ14
            {carry_reg, nibble_carry_flag, zero_reg} <= `CFS_FLAGS_RST; // RQ1
            sp_reg <= `CFS_SP_RST; // RQ8
            gie_reg <= `CFS_GIE_RST;
            lookup_reg <= `CFS_LOOKUP_RST;
            res_data_reg <= 8'h00;
            res_we_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            carry_reg <= carry_next;
            nibble_carry_flag <= nibble_carry_next;
            zero_reg <= zero_next;
            res_data_reg <= res_data_next;
            res_we_reg <= res_we_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next; // RQ21
            if (wr_fire) begin
                case (idx)
                    `CFS_IDX_LOOKUP: begin
                        lookup_reg <= pwdata[7:0];
                    end
                    `CFS_IDX_FLAGS: begin
                        carry_reg <= pwdata[`CFS_FLAG_C]; // RQ1
                        nibble_carry_flag <= pwdata[`CFS_FLAG_DC];
                        zero_reg <= pwdata[`CFS_FLAG_Z];
                    end
                    `CFS_IDX_PCL: begin
                        pc_reg <= {pc_reg[11:8], pwdata[7:0]}; // RQ20
                    end
                    `CFS_IDX_PCH: begin
                        pc_reg <= {pwdata[3:0], pc_reg[7:0]}; // RQ16
                    end
                    `CFS_IDX_STACK_POINTER_CTL: begin
                        gie_reg <= pwdata[`CFS_STACK_POINTER_CTL_GIE]; // RQ8
                        sp_reg <= pwdata[3:0];
                    end
                    default: begin
                        lookup_reg <= lookup_reg;
                    end
                endcase
            end
        end
    end

    // Stack storage has no reset; contents are undefined until written
    always @(posedge clock) begin
        if (push_en) begin
            stk[level_of(sp_reg)] <= push_val; // RQ7
        end else if (wr_fire && is_stk) begin
            if (idx[0]) begin
                stk[stk_ent][11:8] <= pwdata[3:0]; // RQ13
            end else begin
                stk[stk_ent][7:0] <= pwdata[7:0]; // RQ13
            end
        end
    end

    // Read data captured every selected cycle, held when idle
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h0000_0000;
            ex_prev_reg <= 1'b0;
        end else begin
            ex_prev_reg <= ex_valid;
            if (psel) begin
                prdata_reg <= {24'h00_0000, rd_mux};
            end
        end
    end

endmodule

// >>> bench/cfs_core_props.sv
// Checker of the core sequencing block: counter, accumulator and
// result relations at the execute port. Bound to every cfs_core.
`timescale 1ns/1ns
`include "cfs_regs.vh"
module cfs_core_props #(
    parameter [11:0] IRQ_VECTOR = `CFS_IRQ_VEC
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        ex_valid,
    input wire logic [4:0]  ex_op,
    input wire logic [7:0]  ex_operand,
    input wire logic [11:0] ex_target,
    input wire logic        ex_to_mem,
    input wire logic [7:0]  accumulator,
    input wire logic [11:0] pc_out,
    input wire logic [7:0]  res_data,
    input wire logic        res_we
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_step_plain: assert property (ex_valid && ex_op == `CFS_OP_NEXT
        |=> pc_out == $past(pc_out) + 12'h001) else $error("counter did not step");
    a_jump_load: assert property (ex_valid && ex_op == `CFS_OP_JMP
        |=> pc_out == $past(ex_target)) else $error("jump target not loaded");
    a_cmp_skip: assert property (ex_valid && ex_op == `CFS_OP_COMPARE_SKIP
        && accumulator == ex_operand |=> pc_out == $past(pc_out) + 12'h002)
        else $error("equal compare did not skip");
    a_cmp_step: assert property (ex_valid && ex_op == `CFS_OP_COMPARE_SKIP
        && accumulator != ex_operand |=> pc_out == $past(pc_out) + 12'h001)
        else $error("unequal compare skipped");
    a_inc_wrap: assert property (ex_valid && ex_op == `CFS_OP_INCSK
        && !ex_to_mem && ex_operand == 8'hFF
        |=> pc_out == $past(pc_out) + 12'h002 && accumulator == 8'h00)
        else $error("increment wrap did not skip");
    a_page_keep: assert property (ex_valid && ex_op == `CFS_OP_ADDPC
        |=> pc_out == {$past(pc_out[11:8]), $past(pc_out[7:0]) + $past(accumulator)})
        else $error("computed jump left the page");
    a_xch_swap: assert property (ex_valid && ex_op == `CFS_OP_XCH
        |=> res_we && res_data == $past(accumulator) && accumulator == $past(ex_operand))
        else $error("exchange did not swap");
    a_call_return: assert property (ex_valid && ex_op == `CFS_OP_CALL
        ##1 ex_valid && ex_op == `CFS_OP_RET |=> pc_out == $past(pc_out, 2) + 12'h001)
        else $error("return missed call site");
    a_irq_entry: assert property (ex_valid && ex_op == `CFS_OP_IENT
        |=> pc_out == IRQ_VECTOR) else $error("entry vector not loaded");
    a_lda_load: assert property (ex_valid && ex_op == `CFS_OP_LDA
        |=> accumulator == $past(ex_operand)) else $error("load missed accumulator");

    c_call_ret: cover property (ex_valid && ex_op == `CFS_OP_CALL
        ##1 ex_valid && ex_op == `CFS_OP_RET);
    c_cmp_skip: cover property (ex_valid && ex_op == `CFS_OP_COMPARE_SKIP
        && accumulator == ex_operand);
    c_page: cover property (ex_valid && ex_op == `CFS_OP_ADDPC);
endmodule

bind cfs_core cfs_core_props #(.IRQ_VECTOR(IRQ_VECTOR)) cfs_core_props_i (
    .clock(clock), .rstn(rstn), .ex_valid(ex_valid), .ex_op(ex_op),
    .ex_operand(ex_operand), .ex_target(ex_target), .ex_to_mem(ex_to_mem),
    .accumulator(accumulator), .pc_out(pc_out), .res_data(res_data), .res_we(res_we));

// >>> bench/cfs_core_tb.sv
// Self-checking bench of the core sequencing block.
// Drives the execute port directly and the system registers over APB.
`timescale 1ns/1ns
`include "cfs_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module cfs_core_tb;
    localparam [11:0] VEC = 12'h008;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic        ex_valid = 1'b0;
    logic [4:0]  ex_op = 5'h00;
    logic [7:0]  ex_operand = 8'h00;
    logic [11:0] ex_target = 12'h000;
    logic [2:0]  ex_bit = 3'h0;
    logic        ex_to_mem = 1'b0;
    wire  [7:0]  accumulator;
    wire  [11:0] pc_out;
    wire  [7:0]  res_data;
    wire         res_we;
    wire         global_irq_enable;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    logic        err;
    logic [11:0] pc0;
    logic [35:0] row;
    // Op, start acc, operand, bit, acc after, {carry, nibble carry, zero}, skip
    logic [35:0] rows [0:15] = '{
        {`CFS_OP_NEXT, 8'h3C, 8'h00, 3'h0, 8'h3C, 3'h0, 1'b0},
        {`CFS_OP_ADD, 8'h0F, 8'h01, 3'h0, 8'h10, 3'h2, 1'b0},
        {`CFS_OP_ADD, 8'hF0, 8'h10, 3'h0, 8'h00, 3'h5, 1'b0},
        {`CFS_OP_SUB, 8'h10, 8'h01, 3'h0, 8'h0F, 3'h4, 1'b0},
        {`CFS_OP_SUB, 8'h01, 8'h02, 3'h0, 8'hFF, 3'h0, 1'b0},
        {`CFS_OP_RRC, 8'h00, 8'h01, 3'h0, 8'h00, 3'h4, 1'b0},
        {`CFS_OP_RLC, 8'h00, 8'h80, 3'h0, 8'h00, 3'h4, 1'b0},
        {`CFS_OP_COMPARE_SKIP, 8'h12, 8'h12, 3'h0, 8'h12, 3'h0, 1'b1},
        {`CFS_OP_COMPARE_SKIP, 8'h12, 8'h13, 3'h0, 8'h12, 3'h0, 1'b0},
        {`CFS_OP_INCSK, 8'h00, 8'hFF, 3'h0, 8'h00, 3'h0, 1'b1},
        {`CFS_OP_DECSK, 8'h00, 8'h01, 3'h0, 8'h00, 3'h0, 1'b1},
        {`CFS_OP_DECSK, 8'h00, 8'h05, 3'h0, 8'h04, 3'h0, 1'b0},
        {`CFS_OP_BIT_CLEAR_SKIP, 8'h00, 8'hFE, 3'h0, 8'h00, 3'h0, 1'b1},
        {`CFS_OP_BIT_SET_SKIP, 8'h00, 8'h80, 3'h7, 8'h00, 3'h0, 1'b1},
        {`CFS_OP_BIT_SET_SKIP, 8'h00, 8'h7F, 3'h7, 8'h00, 3'h0, 1'b0},
        {`CFS_OP_XCH, 8'h5A, 8'h33, 3'h0, 8'h33, 3'h0, 1'b0}};

    cfs_core #(.IRQ_VECTOR(VEC)) cfs_core_i (
        .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ex_valid(ex_valid), .ex_op(ex_op),
        .ex_operand(ex_operand), .ex_target(ex_target), .ex_bit(ex_bit),
        .ex_to_mem(ex_to_mem), .accumulator(accumulator), .pc_out(pc_out),
        .res_data(res_data), .res_we(res_we), .global_irq_enable(global_irq_enable));

    always #2 clock = ~clock;

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        pstrb <= 4'hF;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(rd, {24'h000000, e})
    endtask

    // Leaves the strobe up so instructions can follow back to back
    task automatic exe(input logic [4:0] op, input logic [7:0] v, input logic [11:0] t);
        @(posedge clock);
        ex_valid <= 1'b1;
        ex_op <= op;
        ex_operand <= v;
        ex_target <= t;
    endtask

    task automatic idle;
        @(posedge clock);
        ex_valid <= 1'b0;
        @(posedge clock);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clock);
        bad_count++;
        tally_and_finish;
    end

    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        `CHK(pc_out, 12'h000)
        rchk(`CFS_IDX_FLAGS, 8'h00);
        rchk(`CFS_IDX_STACK_POINTER_CTL, 8'h0F);
        rchk(`CFS_IDX_PCL, 8'h00);
        rchk(`CFS_IDX_PCH, 8'h00);
        for (int i = 0; i < 16; i++) begin
            row = rows[i];
            apb(1'b1, `CFS_IDX_FLAGS, 8'h00);
            ex_bit <= row[14:12];
            pc0 = pc_out;
            exe(`CFS_OP_LDA, row[30:23], 12'h000);
            exe(row[35:31], row[22:15], 12'h000);
            idle;
            `CHK(accumulator, row[11:4])
            `CHK(pc_out, pc0 + 12'h002 + {11'h000, row[0]})
            apb(1'b0, `CFS_IDX_FLAGS, 8'h00);
            `CHK(rd[2:0], row[3:1])
        end
        apb(1'b1, `CFS_IDX_STACK_POINTER_CTL, 8'h8D);
        @(posedge clock);
        `CHK(global_irq_enable, 1'b1)
        rchk(`CFS_IDX_STACK_POINTER_CTL, 8'h8D);
        apb(1'b1, `CFS_IDX_FLAGS, 8'hFF);
        rchk(`CFS_IDX_FLAGS, 8'h07);
        apb(1'b1, 8'h90, 8'h11);
        `CHK(err, 1'b1)
        apb(1'b1, `CFS_IDX_STACK_POINTER_CTL, 8'h0F);
        exe(`CFS_OP_JMP, 8'h00, 12'h123);
        exe(`CFS_OP_CALL, 8'h00, 12'h456);
        idle;
        `CHK(pc_out, 12'h456)
        rchk(`CFS_IDX_STACK_POINTER_CTL, 8'h0E);
        rchk(8'hFE, 8'h24);
        rchk(8'hFF, 8'h01);
        exe(`CFS_OP_IENT, 8'h00, 12'h000);
        idle;
        `CHK(pc_out, VEC)
        rchk(8'hFC, 8'h56);
        exe(`CFS_OP_RETURN_FROM_INTERRUPT, 8'h00, 12'h000);
        exe(`CFS_OP_RET, 8'h00, 12'h000);
        idle;
        `CHK(pc_out, 12'h124)
        rchk(`CFS_IDX_STACK_POINTER_CTL, 8'h0F);
        apb(1'b1, `CFS_IDX_STACK_POINTER_CTL, 8'h0E);
        apb(1'b1, 8'hFE, 8'h77);
        apb(1'b1, 8'hFF, 8'h03);
        exe(`CFS_OP_RET, 8'h00, 12'h000);
        idle;
        `CHK(pc_out, 12'h377)
        for (int i = 0; i < 9; i++) exe(`CFS_OP_CALL, 8'h00, 12'h200);
        idle;
        rchk(`CFS_IDX_STACK_POINTER_CTL, 8'h06);
        exe(`CFS_OP_CALL, 8'h00, 12'h2A0);
        exe(`CFS_OP_RET, 8'h00, 12'h000);
        idle;
        `CHK(pc_out, 12'h201)
        exe(`CFS_OP_JMP, 8'h00, 12'h3F0);
        exe(`CFS_OP_LDA, 8'h20, 12'h000);
        exe(`CFS_OP_ADDPC, 8'h00, 12'h000);
        idle;
        `CHK(pc_out, 12'h311)
        apb(1'b1, `CFS_IDX_PCL, 8'h28);
        @(posedge clock);
        `CHK(pc_out, 12'h328)
        apb(1'b1, `CFS_IDX_PCH, 8'h05);
        @(posedge clock);
        `CHK(pc_out, 12'h528)
        exe(`CFS_OP_LDA, 8'h44, 12'h000);
        idle;
        ex_to_mem <= 1'b1;
        exe(`CFS_OP_INCSK, 8'hFF, 12'h000);
        idle;
        `CHK({res_we, res_data, accumulator}, 17'h10044)
        ex_to_mem <= 1'b0;
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        rchk(`CFS_IDX_STACK_POINTER_CTL, 8'h0F);
        tally_and_finish;
    end
endmodule
